/* hw/uri_map.vh */
/*
  Register map, field positions, reset values and bus constants of the serial
  channel register interface.
  Assumes inclusion by bare name from the design files; holds definitions only.
*/
`ifndef URI_MAP_VH
`define URI_MAP_VH

// ************************************************************************
// register indices, byte address is four times the index
// ************************************************************************
`define URI_ADDR_W          18
`define URI_IDX_W           16
`define URI_IDX_CLK_SEL     16'h4380
`define URI_IDX_FRAME_MODE  16'h4382
`define URI_IDX_BAUD_RATE   16'h4384
`define URI_IDX_CHAN_CTRL   16'h4386
`define URI_IDX_TX_BYTE     16'h4388
`define URI_IDX_RX_BYTE     16'h438a
`define URI_IDX_STATUS      16'h438c
`define URI_IDX_IRQ_EN      16'h438e

// ************************************************************************
// writable masks and reset values
// ************************************************************************
`define URI_MASK_CLK_SEL    16'h0133
`define URI_MASK_FRAME_MODE 16'h037f
`define URI_MASK_BAUD_RATE  16'h0fff
`define URI_MASK_IRQ_EN     7'h7f
`define URI_RST_REG16       16'h0000
`define URI_RST_BYTE        8'h00
`define URI_RST_STATUS      7'h01

// ************************************************************************
// field positions
// ************************************************************************
`define URI_CLK_DIV_LSB     4
`define URI_MODE_STOP_TWO   0
`define URI_MODE_PAR_ODD    1
`define URI_MODE_PAR_EN     2
`define URI_MODE_CHAR8      3
`define URI_MODE_OPEN_DRAIN 5
`define URI_MODE_PULLUP     6
`define URI_MODE_INV_TX     8
`define URI_MODE_INV_RX     9
`define URI_CTRL_ENABLE     0
`define URI_CTRL_SOFT_RST   1
`define URI_ST_TX_EMPTY     0
`define URI_ST_RX_ONE       1
`define URI_ST_RX_TWO       2
`define URI_ST_OVERRUN      3
`define URI_ST_PARITY       4
`define URI_ST_FRAMING      5
`define URI_ST_TX_END       6
`define URI_ST_TX_BUSY      8
`define URI_ST_RX_BUSY      9

// ************************************************************************
// timing
// ************************************************************************
`define URI_CLK_PERIOD_NS   10
`define URI_PER_W           12

`endif

/* hw/uri_bit_timer.v */
/*
  Bit period timer: a down counter that pulses tick once per bit period.
  Assumes one clock domain and a period of at least one cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module uri_bit_timer #(
  parameter PER_W = 12
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             restart,
  input  wire [PER_W-1:0] load_val,
  input  wire [PER_W-1:0] period,
  output wire             tick
);

  reg [PER_W-1:0] cnt_q;

  // ************************************************************************
  // counter
  // ************************************************************************

  // tick is suppressed during restart so a fresh start never fires early
  assign tick = (cnt_q == {PER_W{1'b0}}) & ~restart;

  // reload with period minus one so ticks stay exactly one period apart
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {PER_W{1'b0}};
    end else if (restart) begin
      cnt_q <= load_val;
    end else if (cnt_q == {PER_W{1'b0}}) begin
      cnt_q <= period - {{(PER_W-1){1'b0}}, 1'b1};
    end else begin
      cnt_q <= cnt_q - {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

/* hw/uri_top.v */
/*
  Serial channel register interface: APB slave, status flags, interrupt,
  transmit shifter and receiver with a two-byte receive buffer.
  Assumes one 100 MHz clock, an asynchronous serial line on RXD_I and an
  APB master that holds each request until PREADY.
*/
// Decided for this implementation: register access over APB.
// Summary of operation
// - tx empty flag resets set, clears on write
// - rx buffer flags read-only, cleared by data read
// - framing/parity errors clear by one or read
// - tx end and overrun clear by one
`timescale 1ns/100ps
`default_nettype none
`include "uri_map.vh"

module uri_top #(
  parameter PER_W = `URI_PER_W
) (
  input  wire                   CLK,
  input  wire                   RSTN,
  input  wire                   PSEL,
  input  wire                   PENABLE,
  input  wire                   PWRITE,
  input  wire [`URI_ADDR_W-1:0] PADDR,
  input  wire [31:0]            PWDATA,
  output wire [31:0]            PRDATA,
  output wire                   PREADY,
  output wire                   PSLVERR,
  input  wire                   RXD_I,
  output wire                   TXD_O,
  output wire                   TXD_OE,
  output wire                   PULLUP_EN,
  output wire                   IRQ
);

  localparam [3:0] RX_IDLE  = 4'b0001;
  localparam [3:0] RX_START = 4'b0010;
  localparam [3:0] RX_DATA  = 4'b0100;
  localparam [3:0] RX_STOP  = 4'b1000;

  // ************************************************************************
  // apb slave
  // ************************************************************************
  reg  [15:0] prdata_q;
  reg         pready_q;
  reg         pslverr_q;
  reg  [15:0] rdata_d;
  reg         hit_d;

  wire [`URI_IDX_W-1:0] idx = PADDR[`URI_ADDR_W-1:2];
  wire aligned = (PADDR[1:0] == 2'b00);
  wire setup   = PSEL & ~PENABLE;
  wire access  = PSEL & PENABLE & pready_q;
  wire wr      = access & PWRITE;
  wire rd      = access & ~PWRITE;

  wire sel_clk  = aligned & (idx == `URI_IDX_CLK_SEL);
  wire sel_mode = aligned & (idx == `URI_IDX_FRAME_MODE);
  wire sel_baud = aligned & (idx == `URI_IDX_BAUD_RATE);
  wire sel_ctrl = aligned & (idx == `URI_IDX_CHAN_CTRL);
  wire sel_txd  = aligned & (idx == `URI_IDX_TX_BYTE);
  wire sel_rxd  = aligned & (idx == `URI_IDX_RX_BYTE);
  wire sel_stat = aligned & (idx == `URI_IDX_STATUS);
  wire sel_en   = aligned & (idx == `URI_IDX_IRQ_EN);

  // ************************************************************************
  // configuration and state registers
  // ************************************************************************
  reg  [15:0] clk_sel_q;
  reg  [15:0] mode_q;
  reg  [15:0] baud_q;
  reg         enable_q;
  reg  [7:0]  tx_buf_q;
  reg  [6:0]  irq_en_q;
  reg         tx_empty_q;
  reg         tx_end_q;
  reg         overrun_q;
  reg         parity_err_q;
  reg         framing_err_q;
  reg  [7:0]  rx_head_q;
  reg  [7:0]  rx_next_q;
  reg  [1:0]  rx_cnt_q;
  reg         irq_q;

  wire wr_txd   = wr & sel_txd;
  wire rd_rxd   = rd & sel_rxd;
  wire wr_stat  = wr & sel_stat;
  // software reset is a one-shot; the bit always reads back zero
  wire soft_rst = wr & sel_ctrl & PWDATA[`URI_CTRL_SOFT_RST];

  wire stop_two   = mode_q[`URI_MODE_STOP_TWO];
  wire par_odd    = mode_q[`URI_MODE_PAR_ODD];
  wire par_en     = mode_q[`URI_MODE_PAR_EN];
  wire char8      = mode_q[`URI_MODE_CHAR8];
  wire open_drain = mode_q[`URI_MODE_OPEN_DRAIN];
  wire inv_tx     = mode_q[`URI_MODE_INV_TX];
  wire inv_rx     = mode_q[`URI_MODE_INV_RX];

  // bit period is (rate bits 7:0 + 1) cycles scaled by the power-of-two divider
  wire [1:0]       clk_div = clk_sel_q[`URI_CLK_DIV_LSB+1:`URI_CLK_DIV_LSB];
  wire [PER_W-1:0] period  = ({{(PER_W-8){1'b0}}, baud_q[7:0]} +
                              {{(PER_W-1){1'b0}}, 1'b1}) << clk_div;

  // derived receive buffer flags: read-only, popped by a data read
  wire rx_one = (rx_cnt_q != 2'd0);
  wire rx_two = (rx_cnt_q == 2'd2);

  // ************************************************************************
  // transmitter
  // ************************************************************************
  reg  [11:0] tx_sh_q;
  reg  [3:0]  tx_left_q;
  reg         tx_line_q;
  reg         txd_q;
  reg         txd_oe_q;
  reg  [11:0] tx_frame;
  reg  [3:0]  tx_bits;
  wire        tx_tick;

  wire tx_busy = (tx_left_q != 4'd0);
  wire tx_load = enable_q & ~tx_empty_q & ~tx_busy & ~soft_rst;
  wire tx_done = tx_busy & tx_tick & (tx_left_q == 4'd1);
  wire tx_par  = (char8 ? ^tx_buf_q : ^tx_buf_q[6:0]) ^ par_odd;

  // frame is sent lsb first: start, data, optional parity, stop bits
  always @* begin
    tx_frame    = 12'hfff;
    tx_frame[0] = 1'b0;
    if (char8) begin
      tx_frame[9:1] = {(par_en ? tx_par : 1'b1), tx_buf_q};
    end else begin
      tx_frame[8:1] = {(par_en ? tx_par : 1'b1), tx_buf_q[6:0]};
    end
    // start, data, parity and stop bits all count, so the last stop bit gets a full period
    tx_bits = 4'd9 + {3'd0, char8} + {3'd0, par_en} + {3'd0, stop_two};
  end

  uri_bit_timer #(
    .PER_W (PER_W)
  ) u_tx_timer (
    .clk      (CLK),
    .rst_n    (RSTN),
    .restart  (tx_load),
    .load_val (period - {{(PER_W-1){1'b0}}, 1'b1}),
    .period   (period),
    .tick     (tx_tick)
  );

  // shifter; clearing the channel enable abandons a frame in flight
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_sh_q   <= 12'hfff;
      tx_left_q <= 4'd0;
      tx_line_q <= 1'b1;
    end else if (soft_rst | ~enable_q) begin
      tx_sh_q   <= 12'hfff;
      tx_left_q <= 4'd0;
      tx_line_q <= 1'b1;
    end else if (tx_load) begin
      tx_sh_q   <= tx_frame;
      tx_left_q <= tx_bits;
      tx_line_q <= tx_frame[0];
    end else if (tx_busy & tx_tick) begin
      tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
      tx_left_q <= tx_left_q - 4'd1;
      tx_line_q <= tx_done ? 1'b1 : tx_sh_q[1];
    end
  end

  // pin drivers; open-drain mode only drives the low level
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      txd_q    <= 1'b1;
      txd_oe_q <= 1'b1;
    end else begin
      txd_q    <= tx_line_q ^ inv_tx;
      txd_oe_q <= open_drain ? ~(tx_line_q ^ inv_tx) : 1'b1;
    end
  end

  // ************************************************************************
  // receiver
  // ************************************************************************
  reg  [3:0] rx_state_q;
  reg  [8:0] rx_sh_q;
  reg  [3:0] rx_idx_q;
  reg        rx_s1_q;
  reg        rx_s2_q;
  reg        rx_s3_q;
  wire       rx_tick;

  wire       rx_in    = rx_s2_q ^ inv_rx;
  wire       rx_prev  = rx_s3_q ^ inv_rx;
  // a falling edge, not a low level, starts a frame: a low stop bit must not restart
  wire       rx_begin = enable_q & rx_state_q[0] & ~rx_in & rx_prev & ~soft_rst;
  wire [3:0] rx_nbits = 4'd7 + {3'd0, char8} + {3'd0, par_en};
  wire       rx_done  = rx_state_q[3] & rx_tick;
  wire [7:0] rx_data  = char8 ? rx_sh_q[7:0] : {1'b0, rx_sh_q[6:0]};
  wire       rx_pbit  = char8 ? rx_sh_q[8] : rx_sh_q[7];
  wire       rx_perr  = par_en & (^rx_data ^ rx_pbit ^ par_odd);
  wire       rx_ferr  = ~rx_in;

  // two flip-flops before the line is looked at
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= RXD_I;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  // half-period first load puts every sample at the middle of its bit
  uri_bit_timer #(
    .PER_W (PER_W)
  ) u_rx_timer (
    .clk      (CLK),
    .rst_n    (RSTN),
    .restart  (rx_begin),
    .load_val (period >> 1),
    .period   (period),
    .tick     (rx_tick)
  );

  // only the first stop bit is checked, so two-stop frames pack tighter
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_state_q <= RX_IDLE;
      rx_sh_q    <= 9'h000;
      rx_idx_q   <= 4'd0;
    end else if (soft_rst | ~enable_q) begin
      rx_state_q <= RX_IDLE;
      rx_idx_q   <= 4'd0;
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          if (rx_begin) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
            rx_idx_q   <= 4'd0;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_sh_q[rx_idx_q] <= rx_in;
            rx_idx_q          <= rx_idx_q + 4'd1;
            if (rx_idx_q == rx_nbits - 4'd1) begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // ************************************************************************
  // receive buffer, two entries deep
  // ************************************************************************

  // a byte landing while both entries are full is dropped; read and push
  // in the same cycle keep the count unless the buffer is empty
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_head_q <= `URI_RST_BYTE;
      rx_next_q <= `URI_RST_BYTE;
      rx_cnt_q  <= 2'd0;
    end else if (soft_rst) begin
      rx_cnt_q  <= 2'd0;
    end else if (rx_done & rd_rxd & rx_one) begin
      if (rx_two) begin
        rx_head_q <= rx_next_q;
        rx_next_q <= rx_data;
      end else begin
        rx_head_q <= rx_data;
      end
    end else if (rx_done & ~rx_two) begin
      if (rx_one) begin
        rx_next_q <= rx_data;
      end else begin
        rx_head_q <= rx_data;
      end
      rx_cnt_q <= rx_cnt_q + 2'd1;
    end else if (rd_rxd & rx_one) begin
      rx_head_q <= rx_next_q;
      rx_cnt_q  <= rx_cnt_q - 2'd1;
    end
  end

  // ************************************************************************
  // status flags, set wins over clear except tx empty, where a data write wins over a load
  // ************************************************************************
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_empty_q    <= 1'b1;
      tx_end_q      <= 1'b0;
      overrun_q     <= 1'b0;
      parity_err_q  <= 1'b0;
      framing_err_q <= 1'b0;
    end else if (soft_rst) begin
      tx_empty_q    <= 1'b1;
      tx_end_q      <= 1'b0;
      overrun_q     <= 1'b0;
      parity_err_q  <= 1'b0;
      framing_err_q <= 1'b0;
    end else begin
      // only a data write clears this flag; it wins over a load in the same
      // cycle, since the freshly written byte is then still pending
      if (wr_txd) begin
        tx_empty_q <= 1'b0;
      end else if (tx_load) begin
        tx_empty_q <= 1'b1;
      end
      if (tx_done & tx_empty_q) begin
        tx_end_q <= 1'b1;
      end else if (wr_stat & PWDATA[`URI_ST_TX_END]) begin
        tx_end_q <= 1'b0;
      end
      if (rx_done & rx_two & ~rd_rxd) begin
        overrun_q <= 1'b1;
      end else if (wr_stat & PWDATA[`URI_ST_OVERRUN]) begin
        overrun_q <= 1'b0;
      end
      if (rx_done & rx_perr) begin
        parity_err_q <= 1'b1;
      end else if ((wr_stat & PWDATA[`URI_ST_PARITY]) | rd_rxd) begin
        parity_err_q <= 1'b0;
      end
      if (rx_done & rx_ferr) begin
        framing_err_q <= 1'b1;
      end else if ((wr_stat & PWDATA[`URI_ST_FRAMING]) | rd_rxd) begin
        framing_err_q <= 1'b0;
      end
    end
  end

  wire [6:0] flags = {tx_end_q, framing_err_q, parity_err_q, overrun_q,
                      rx_two, rx_one, tx_empty_q};

  // ************************************************************************
  // software registers and interrupt
  // ************************************************************************
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      clk_sel_q <= `URI_RST_REG16;
      mode_q    <= `URI_RST_REG16;
      baud_q    <= `URI_RST_REG16;
      enable_q  <= 1'b0;
      tx_buf_q  <= `URI_RST_BYTE;
      irq_en_q  <= 7'h00;
      irq_q     <= 1'b0;
    end else begin
      if (wr & sel_clk) begin
        clk_sel_q <= PWDATA[15:0] & `URI_MASK_CLK_SEL;
      end
      if (wr & sel_mode) begin
        mode_q <= PWDATA[15:0] & `URI_MASK_FRAME_MODE;
      end
      if (wr & sel_baud) begin
        baud_q <= PWDATA[15:0] & `URI_MASK_BAUD_RATE;
      end
      if (wr & sel_ctrl) begin
        enable_q <= PWDATA[`URI_CTRL_ENABLE];
      end
      if (wr_txd) begin
        tx_buf_q <= PWDATA[7:0];
      end
      if (wr & sel_en) begin
        irq_en_q <= PWDATA[6:0] & `URI_MASK_IRQ_EN;
      end
      irq_q <= |(flags & irq_en_q);
    end
  end

  // read data is captured in the setup cycle; reserved bits read zero
  always @* begin
    rdata_d = 16'h0000;
    hit_d   = 1'b1;
    if (sel_clk) begin
      rdata_d = clk_sel_q;
    end else if (sel_mode) begin
      rdata_d = mode_q;
    end else if (sel_baud) begin
      rdata_d = baud_q;
    end else if (sel_ctrl) begin
      rdata_d = {15'h0000, enable_q};
    end else if (sel_txd) begin
      rdata_d = {8'h00, tx_buf_q};
    end else if (sel_rxd) begin
      rdata_d = {8'h00, rx_head_q};
    end else if (sel_stat) begin
      rdata_d = {6'h00, ~rx_state_q[0], tx_busy, 1'b0, flags};
    end else if (sel_en) begin
      rdata_d = {9'h000, irq_en_q};
    end else begin
      hit_d = 1'b0;
    end
  end

  // one wait-free access phase: ready rises right after the setup cycle
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      prdata_q  <= 16'h0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= PWRITE ? 16'h0000 : rdata_d;
      pready_q  <= 1'b1;
      pslverr_q <= ~hit_d;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign PRDATA    = {16'h0000, prdata_q};
  assign PREADY    = pready_q;
  assign PSLVERR   = pslverr_q;
  assign TXD_O     = txd_q;
  assign TXD_OE    = txd_oe_q;
  assign PULLUP_EN = mode_q[`URI_MODE_PULLUP];
  assign IRQ       = irq_q;

endmodule

`default_nettype wire

/* test/uri_top_asserts.sv */
/*
  Port checker for the serial channel register interface.
  Assumes binding to uri_top, one clock CLK and active-low reset RSTN.
*/
`timescale 1ns/100ps
`default_nettype none
`include "uri_map.vh"

module uri_top_asserts (
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [17:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        TXD_O,
  input wire logic        TXD_OE,
  input wire logic        IRQ
);
  // ************************************************************
  // helper state and properties
  // ************************************************************
  localparam logic [17:0] A_TX = {`URI_IDX_TX_BYTE, 2'b00};
  localparam logic [17:0] A_ST = {`URI_IDX_STATUS, 2'b00};
  localparam logic [17:0] A_IE = {`URI_IDX_IRQ_EN, 2'b00};
  logic acc;
  logic tx_written_q;
  logic en_written_q;

  assign acc = PSEL && PENABLE && PREADY;

  // conservative: soft reset is not tracked, which only weakens the checks
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_written_q <= 1'b0;
      en_written_q <= 1'b0;
    end else begin
      if (acc && PWRITE && PADDR == A_TX) tx_written_q <= 1'b1;
      if (acc && PWRITE && PADDR == A_IE && PWDATA[6:0] != 7'h00) en_written_q <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  property p_ready_after_setup; PSEL && !PENABLE |=> PREADY; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  property p_ready_one; PREADY |=> !PREADY; endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready longer than one cycle");
  property p_slverr_misaligned; acc && PADDR[1:0] != 2'b00 |-> PSLVERR; endproperty
  a_slverr_misaligned: assert property (p_slverr_misaligned) else $error("misaligned not refused");
  property p_upper_zero; PREADY |-> PRDATA[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read data not zero");
  property p_write_zero; acc && PWRITE |-> PRDATA == 32'h0000_0000; endproperty
  a_write_zero: assert property (p_write_zero) else $error("read data on a write");
  property p_tx_empty_kept;
    acc && !PWRITE && PADDR == A_ST && !tx_written_q |-> PRDATA[0];
  endproperty
  a_tx_empty_kept: assert property (p_tx_empty_kept) else $error("tx empty low unwritten");
  property p_irq_needs_enable; !en_written_q |-> ##1 !IRQ; endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("irq with no enable");
  property p_od_release; !TXD_OE |-> TXD_O; endproperty
  a_od_release: assert property (p_od_release) else $error("released line not high");
endmodule

bind uri_top uri_top_asserts u_chk (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .TXD_O(TXD_O), .TXD_OE(TXD_OE), .IRQ(IRQ));

`default_nettype wire

/* test/uri_remote_dev.sv */
/*
  Remote serial device: sends frames on line_out, decodes frames from line_in.
  Assumes 8 data bits, LSB first, line idle high, period in clk cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module uri_remote_dev #(
  parameter int PERIOD = 4
) (
  input  wire logic clk,
  input  wire logic line_in,
  output var  logic line_out
);
  // ************************************************************
  // frame sender and receiver
  // ************************************************************
  logic [7:0] last_byte;
  logic [7:0] got;

  initial line_out = 1'b1;

  // one frame; bad_par and bad_stop break it on purpose
  task automatic send(input logic [7:0] d, input logic par_en, input logic bad_par,
                      input logic bad_stop);
    logic [10:0] bits;
    int          n;
    bits = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
    n = par_en ? 11 : 10;
    if (!par_en) bits[9] = ~bad_stop;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      line_out <= bits[i];
      repeat (PERIOD - 1) @(posedge clk);
    end
    // idle gap lets the receiver finish before software looks
    @(posedge clk);
    line_out <= 1'b1;
    repeat (PERIOD + 4) @(posedge clk);
  endtask

  // sample at mid-bit, counting clock edges from the start edge
  initial begin
    last_byte = 8'h00;
    forever begin
      @(negedge line_in);
      repeat (PERIOD / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (PERIOD) @(posedge clk);
        got[i] = line_in;
      end
      repeat (PERIOD) @(posedge clk);
      last_byte = got;
    end
  end
endmodule

`default_nettype wire

/* test/uart_register_interface_tb.sv */
/*
  Testbench of the serial channel register interface over APB.
  Assumes uri_top, the remote device model and a 100 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "uri_map.vh"

module uart_register_interface_tb;
  // ************************************************************
  // stimulus, checks and scenarios
  // ************************************************************
  localparam logic [17:0] A_BR = {`URI_IDX_BAUD_RATE, 2'b00};
  localparam logic [17:0] A_MD = {`URI_IDX_FRAME_MODE, 2'b00};
  localparam logic [17:0] A_CT = {`URI_IDX_CHAN_CTRL, 2'b00};
  localparam logic [17:0] A_TX = {`URI_IDX_TX_BYTE, 2'b00};
  localparam logic [17:0] A_RX = {`URI_IDX_RX_BYTE, 2'b00};
  localparam logic [17:0] A_ST = {`URI_IDX_STATUS, 2'b00};
  localparam logic [17:0] A_IE = {`URI_IDX_IRQ_EN, 2'b00};
  logic        CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, TXD_O, TXD_OE, IRQ, rxd;
  logic        PULLUP_EN;
  logic [17:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdata;
  logic        rerr;
  int          failures, checks_done, n;
  wire         txd_line = TXD_OE ? TXD_O : 1'b1;

  uri_top uut (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RXD_I(rxd), .TXD_O(TXD_O), .TXD_OE(TXD_OE), .PULLUP_EN(PULLUP_EN), .IRQ(IRQ));
  uri_remote_dev #(.PERIOD(4)) remote (.clk(CLK), .line_in(txd_line), .line_out(rxd));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic finish_test();
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] wd);
    int k;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 16);
    if (PREADY !== 1'b1) begin
      failures++;
      finish_test();
    end
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic stm(input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, A_ST, 32'h0);
    chk("status", rdata & mask, exp);
  endtask

  // bounded poll of the status flags
  task automatic wait_st(input logic [31:0] mask);
    n = 0;
    do begin
      apb(1'b0, A_ST, 32'h0);
      n++;
    end while ((rdata & mask) !== mask && n < 200);
    if ((rdata & mask) !== mask) begin
      failures++;
      finish_test();
    end
  endtask

  initial begin
    {PSEL, PENABLE, PWRITE, RSTN} = 4'b0000;
    PADDR = 18'h00000;
    PWDATA = 32'h0;
    failures = 0;
    checks_done = 0;
    repeat (12) @(posedge CLK);
    RSTN <= 1'b1;
    stm(32'hffff_ffff, 32'h1);
    apb(1'b0, A_IE, 32'h0);
    chk("irq_enables", rdata, 32'h0);
    apb(1'b1, A_ST, 32'hffff);
    stm(32'h7f, 32'h01);
    // period of four cycles keeps frames short; open drain, line pulled up here
    apb(1'b1, A_BR, 32'h3);
    apb(1'b1, A_MD, 32'h28);
    apb(1'b1, A_TX, 32'ha5);
    stm(32'h7f, 32'h00);
    apb(1'b1, A_CT, 32'h1);
    wait_st(32'h40);
    chk("tx_frame", {24'h0, remote.last_byte}, 32'ha5);
    stm(32'h7f, 32'h41);
    apb(1'b1, A_ST, 32'h0);
    stm(32'h7f, 32'h41);
    apb(1'b1, A_ST, 32'h40);
    stm(32'h7f, 32'h01);
    // interrupt raised by the enabled empty flag, then masked
    apb(1'b1, A_IE, 32'h01);
    repeat (2) @(posedge CLK);
    chk("irq", {31'h0, IRQ}, 32'h1);
    apb(1'b1, A_IE, 32'h0);
    repeat (2) @(posedge CLK);
    chk("irq", {31'h0, IRQ}, 32'h0);
    // three bytes into a two-byte buffer
    remote.send(8'h11, 1'b0, 1'b0, 1'b0);
    remote.send(8'h22, 1'b0, 1'b0, 1'b0);
    remote.send(8'h33, 1'b0, 1'b0, 1'b0);
    stm(32'h7f, 32'h0f);
    apb(1'b1, A_ST, 32'h06);
    stm(32'h7f, 32'h0f);
    apb(1'b0, A_RX, 32'h0);
    chk("rx_byte", rdata, 32'h11);
    stm(32'h7f, 32'h0b);
    apb(1'b1, A_ST, 32'h08);
    stm(32'h7f, 32'h03);
    apb(1'b0, A_RX, 32'h0);
    chk("rx_byte", rdata, 32'h22);
    stm(32'h7f, 32'h01);
    // framing error: cleared by writing one, then by a data read
    remote.send(8'h5a, 1'b0, 1'b0, 1'b1);
    stm(32'h20, 32'h20);
    apb(1'b1, A_ST, 32'h20);
    stm(32'h20, 32'h00);
    remote.send(8'h5a, 1'b0, 1'b0, 1'b1);
    stm(32'h20, 32'h20);
    apb(1'b0, A_RX, 32'h0);
    stm(32'h20, 32'h00);
    // parity error with even parity enabled, pull-up requested
    apb(1'b1, A_MD, 32'h4c);
    remote.send(8'h3c, 1'b1, 1'b1, 1'b0);
    chk("pullup", {31'h0, PULLUP_EN}, 32'h1);
    stm(32'h10, 32'h10);
    apb(1'b1, A_ST, 32'h10);
    stm(32'h10, 32'h00);
    remote.send(8'h3c, 1'b1, 1'b1, 1'b0);
    stm(32'h10, 32'h10);
    apb(1'b0, A_RX, 32'h0);
    stm(32'h10, 32'h00);
    // unmapped and misaligned places are refused
    apb(1'b0, 18'h00000, 32'h0);
    chk("unmapped_err", {31'h0, rerr}, 32'h1);
    apb(1'b0, A_ST + 18'h1, 32'h0);
    chk("misaligned_err", {31'h0, rerr}, 32'h1);
    chk("misaligned_data", rdata, 32'h0);
    finish_test();
  end
endmodule

`default_nettype wire
